/* File: verilog/iesr_pkg.sv */
// shared constants and types for the i/o error status block
package iesr_pkg;

	// register byte offsets, one aligned 32-bit word each
	localparam logic [7:0] OFS_FLAGS_LO = 8'h00;
	localparam logic [7:0] OFS_FLAGS_HI = 8'h04;
	localparam logic [7:0] OFS_ENABLE_LO = 8'h08;
	localparam logic [7:0] OFS_ENABLE_HI = 8'h0c;
	localparam logic [7:0] OFS_UNUSED2_LO = 8'h10;
	localparam logic [7:0] OFS_UNUSED2_HI = 8'h14;
	localparam logic [7:0] OFS_UNUSED3_LO = 8'h18;
	localparam logic [7:0] OFS_UNUSED3_HI = 8'h1c;
	localparam logic [7:0] OFS_CTRL_LO = 8'h20;
	localparam logic [7:0] OFS_CTRL_HI = 8'h24;
	localparam logic [7:0] OFS_ROUTER_LO = 8'h28;
	localparam logic [7:0] OFS_ROUTER_HI = 8'h2c;

	// error flag bit positions
	localparam int ERR_INCHAN_LO = 47;
	localparam int ERR_MSG_LO = 49;
	localparam int ERR_SDMA_LO = 54;
	localparam int ERR_MDMA_RD = 60;
	localparam int ERR_MDMA_WR = 61;
	localparam int ERR_MDMA_PAR = 62;
	localparam int ERR_MDMA_FMT = 63;

	// widths of the error source groups
	localparam int INCHAN_W = 2;
	localparam int MSG_W = 5;
	localparam int SDMA_W = 6;
	localparam int MDMA_PAR_W = 3;
	localparam int MDMA_CH = 2;

	// control/status fields
	localparam int CS_PORT_LO = 0;
	localparam int CS_PORT_W = 4;
	localparam int CS_REV_LO = 8;
	localparam int CS_REV_W = 7;
	localparam int CS_SCAN_BIT = 16;

	// router status summary bit, seen in the high word
	localparam int ROUTER_SUM_BIT = 42;
	localparam int WORD_W = 32;

	// ahb-lite encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// nak retry counting
	localparam int RETRY_W = 4;
	localparam logic [RETRY_W-1:0] RETRY_LIMIT_DEF = 4'h4;

	// bus data phase
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_RDWAIT,
		PH_RDDONE
	} iesr_phase_e;

	// whole state of the main module
	typedef struct packed {
		iesr_phase_e phase;
		logic [7:0] addr;
		logic [63:0] flags;
		logic [63:0] enable;
		logic [CS_PORT_W-1:0] portDis;
		logic scanEn;
		logic routerSum;
		logic [MDMA_CH-1:0][RETRY_W-1:0] retryCnt;
		logic [WORD_W-1:0] rdata;
	} iesr_state_s;

endpackage

/* File: verilog/iesr_reset_sync.sv */
// reset release synchroniser
`timescale 1ns/1ns
module iesr_reset_sync (
	// clock and raw reset
	input wire logic clk,
	input wire logic nrst,
	// released reset copy
	output logic rstSyncN
);

	logic [1:0] sync_reg;

	// assert at once, release after two edges to avoid metastable release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_reg <= 2'h0;
		end else begin
			sync_reg <= {sync_reg[0], 1'b1};
		end
	end

	assign rstSyncN = sync_reg[1];

endmodule

/* File: verilog/iesr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module iesr_pin_sync #(
	parameter int W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// pin side
	input wire logic [W-1:0] pin,
	// filtered value
	output logic [W-1:0] value
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] value_reg;

	// stage one feeds only stage two; value moves when two and three agree
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			value_reg <= '0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				value_reg <= s3_reg;
			end
		end
	end

	assign value = value_reg;

endmodule

/* File: verilog/iesr_error_status.sv */
// error flags, interrupt enables and control/status registers on ahb-lite
`timescale 1ns/1ns
module iesr_error_status #(
	parameter logic [iesr_pkg::RETRY_W-1:0] RETRY_LIMIT = iesr_pkg::RETRY_LIMIT_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// error sources, one-cycle pulses on clk
	input wire logic [iesr_pkg::ERR_INCHAN_LO-1:0] errLower,
	input wire logic [iesr_pkg::INCHAN_W-1:0] inChanErr,
	input wire logic [iesr_pkg::MSG_W-1:0] msgErr,
	input wire logic [iesr_pkg::SDMA_W-1:0] slaveDmaErr,
	input wire logic [iesr_pkg::MDMA_PAR_W-1:0] mdmaParityErr,
	input wire logic mdmaFormatErr,
	// master dma send responses, index 0 read, 1 write
	input wire logic [iesr_pkg::MDMA_CH-1:0] mdmaRspValid,
	input wire logic [iesr_pkg::MDMA_CH-1:0] mdmaSendErrState,
	input wire logic [iesr_pkg::MDMA_CH-1:0] mdmaIllegalFlags,
	input wire logic [iesr_pkg::MDMA_CH-1:0] mdmaNak,
	// board pins
	input wire logic [iesr_pkg::CS_REV_W-1:0] boardRevisionPin,
	// controls and interrupt
	output logic [iesr_pkg::CS_PORT_W-1:0] portDisable,
	output logic scanMasterEnable,
	output logic irq
);
	import iesr_pkg::*;

	// register map, one aligned word per offset, low half of a 64-bit register first:
	//   0x00 flags low, write one to clear
	//   0x04 flags high, write one to clear
	//   0x08 enable low, read/write
	//   0x0c enable high, read/write
	//   0x10..0x1c two spare 64-bit registers, read zero, writes dropped
	//   0x20 control/status low: port disables, board revision, scan enable
	//   0x24 control/status high, reads zero
	//   0x28 router status low, reads zero
	//   0x2c router status high, only the summary bit, write one to clear
	// any other offset reads zero and drops writes; the answer is always okay,
	// so software cannot learn of a bad address from the bus response itself
	// only haddr[7:2] is decoded, so the map repeats every 256 bytes

	logic rstN;
	logic [CS_REV_W-1:0] boardRevision;
	iesr_state_s s_reg;
	iesr_state_s s_next;

	// internal reset copy
	iesr_reset_sync u_rst (
		.clk(clk),
		.nrst(nrst),
		.rstSyncN(rstN)
	);

	// revision straps come from pins outside the clock domain
	// three stages and an agreement test cost four cycles of latency after
	// reset, which is harmless for a value that only changes with the board
	iesr_pin_sync #(
		.W(CS_REV_W)
	) u_rev (
		.clk(clk),
		.rstN(rstN),
		.pin(boardRevisionPin),
		.value(boardRevision)
	);

	// register read mux; unmapped words read zero
	// it works on the registered state only, so a read never sees a value
	// half way through an update; the bus wait state pays for that
	// the control word mixes writable fields with the live revision strap
	function automatic logic [WORD_W-1:0] readWord(
		input logic [7:0] a,
		input iesr_state_s st,
		input logic [CS_REV_W-1:0] rev
	);
		logic [WORD_W-1:0] w;
		w = '0;
		case (a)
			OFS_FLAGS_LO: begin
				w = st.flags[WORD_W-1:0];
			end
			OFS_FLAGS_HI: begin
				w = st.flags[2*WORD_W-1:WORD_W];
			end
			OFS_ENABLE_LO: begin
				w = st.enable[WORD_W-1:0];
			end
			OFS_ENABLE_HI: begin
				w = st.enable[2*WORD_W-1:WORD_W];
			end
			OFS_UNUSED2_LO, OFS_UNUSED2_HI, OFS_UNUSED3_LO, OFS_UNUSED3_HI: begin
				w = '0;
			end
			OFS_CTRL_LO: begin
				w[CS_PORT_LO +: CS_PORT_W] = st.portDis;
				w[CS_REV_LO +: CS_REV_W] = rev;
				w[CS_SCAN_BIT] = st.scanEn;
			end
			OFS_ROUTER_HI: begin
				w[ROUTER_SUM_BIT - WORD_W] = st.routerSum;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction

	// next state: bus phases, register writes and error capture
	always_comb begin
		logic accept;
		logic wordOk;
		logic [63:0] errSet;
		logic [63:0] flagClr;
		logic [63:0] newlySet;
		logic routerClr;
		logic [MDMA_CH-1:0] retryFail;
		logic [MDMA_CH-1:0] badRsp;
		s_next = s_reg;
		accept = hsel && htrans[1] && hready;
		wordOk = (hsize == HSIZE_WORD);
		errSet = '0;
		flagClr = '0;
		newlySet = '0;
		routerClr = 1'b0;
		retryFail = '0;
		badRsp = '0;

		// data phase of a write: act on the address held from the address phase
		// writes land one edge after acceptance, when hwdata stands on the bus;
		// a clear request is only a mask here, applied below with set priority
		if (s_reg.phase == PH_WRITE) begin
			case (s_reg.addr)
				OFS_FLAGS_LO: begin
					flagClr[WORD_W-1:0] = hwdata;
				end
				OFS_FLAGS_HI: begin
					flagClr[2*WORD_W-1:WORD_W] = hwdata;
				end
				OFS_ENABLE_LO: begin
					s_next.enable[WORD_W-1:0] = hwdata;
				end
				OFS_ENABLE_HI: begin
					s_next.enable[2*WORD_W-1:WORD_W] = hwdata;
				end
				OFS_CTRL_LO: begin
					s_next.portDis = hwdata[CS_PORT_LO +: CS_PORT_W];
					s_next.scanEn = hwdata[CS_SCAN_BIT];
				end
				OFS_ROUTER_HI: begin
					routerClr = hwdata[ROUTER_SUM_BIT - WORD_W];
				end
				default: begin
					// reserved and unused words take no write
					routerClr = 1'b0;
				end
			endcase
		end

		// read data is fetched one cycle late, after any prior write landed
		if (s_reg.phase == PH_RDWAIT) begin
			s_next.rdata = readWord(s_reg.addr, s_reg, boardRevision);
		end

		// bus phase sequencing
		unique case (s_reg.phase)
			PH_RDWAIT: begin
				s_next.phase = PH_RDDONE;
			end
			PH_IDLE, PH_WRITE, PH_RDDONE: begin
				if (accept) begin
					s_next.addr = {haddr[7:2], 2'h0};
					if (!hwrite) begin
						s_next.phase = PH_RDWAIT;
					end else if (wordOk) begin
						s_next.phase = PH_WRITE;
					end else begin
						s_next.phase = PH_IDLE;
					end
				end else begin
					s_next.phase = PH_IDLE;
				end
			end
		endcase

		// master dma send responses and nak retry counting per channel
		// each channel counts consecutive naks; a clean reply or any answer
		// without nak restarts the count, so only an unbroken run exhausts it
		// the flag sets on the nak that finds the count already at the limit,
		// i.e. one nak more than the limit, and the count then starts again
		// a reply that carries a nak is never judged for its state flags
		for (int i = 0; i < MDMA_CH; i++) begin
			if (mdmaRspValid[i]) begin
				if (mdmaNak[i]) begin
					if (s_reg.retryCnt[i] >= RETRY_LIMIT) begin
						retryFail[i] = 1'b1;
						s_next.retryCnt[i] = '0;
					end else begin
						s_next.retryCnt[i] = s_reg.retryCnt[i] + RETRY_W'(1);
					end
				end else begin
					s_next.retryCnt[i] = '0;
					badRsp[i] = mdmaSendErrState[i] | mdmaIllegalFlags[i];
				end
			end
		end

		// gather error events onto their flag positions
		// flag layout seen from the error inputs:
		//   46..0  lower sources, passed through unchanged
		//   47..48 input channel sram and ring parity
		//   49..53 message control, five sources in input order
		//   54..59 slave dma control, six sources in input order
		//   60     read-side send response trouble or retries exhausted
		//   61     write-side send response trouble or retries exhausted
		//   62     any of the three master dma parity sources
		//   63     master dma response format error
		// sources are already on clk and need no synchroniser; a one-cycle
		// pulse is enough, a longer one only keeps setting the same flag
		errSet[ERR_INCHAN_LO-1:0] = errLower;
		errSet[ERR_INCHAN_LO +: INCHAN_W] = inChanErr;
		errSet[ERR_MSG_LO +: MSG_W] = msgErr;
		errSet[ERR_SDMA_LO +: SDMA_W] = slaveDmaErr;
		errSet[ERR_MDMA_RD] = badRsp[0] | retryFail[0];
		errSet[ERR_MDMA_WR] = badRsp[1] | retryFail[1];
		errSet[ERR_MDMA_PAR] = |mdmaParityErr;
		errSet[ERR_MDMA_FMT] = mdmaFormatErr;

		// sticky flags, write one to clear; a new event beats the clear
		s_next.flags = (s_reg.flags & ~flagClr) | errSet;

		// summary only for flags rising while already enabled
		// enabling a flag that is already set raises irq but not the summary;
		// a flag that sets again while still set does not count as new either
		// the summary is sticky as well and is cleared by writing one to it
		newlySet = errSet & ~s_reg.flags & s_reg.enable;
		s_next.routerSum = (s_reg.routerSum & ~routerClr) | (|newlySet);
	end

	// single state register
	// reset comes from the released copy, so every field leaves reset on the
	// same edge; enables start at zero, so no interrupt can fire before
	// software has set up the mask
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s_reg <= '{
				phase: PH_IDLE,
				addr: '0,
				flags: '0,
				enable: '0,
				portDis: '0,
				scanEn: 1'b0,
				routerSum: 1'b0,
				retryCnt: '0,
				rdata: '0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// bus answers: writes without wait, reads with one wait state
	// the wait state lets a read that follows a write see the written value,
	// trading one cycle per read for a read mux off registered state only
	// hreadyout is decoded straight from the phase register, so it is glitch
	// free; hrdata holds the last read word until the next read loads it
	assign hreadyout = (s_reg.phase != PH_RDWAIT);
	assign hresp = HRESP_OKAY;
	assign hrdata = s_reg.rdata;

	// controls driven straight from their register fields
	assign portDisable = s_reg.portDis;
	assign scanMasterEnable = s_reg.scanEn;

	// level interrupt while any enabled flag is set
	// irq follows the registered flags and enables with no extra delay;
	// it stays high until every enabled flag is cleared or masked off
	// disabled flags still record their errors and can be polled
	assign irq = |(s_reg.flags & s_reg.enable);

endmodule

/* File: tb/iesr_error_status_asserts.sv */
// port assertions for the error status block
`timescale 1ns/1ns
module iesr_status_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// outputs
	input wire logic [3:0] portDisable,
	input wire logic scanMasterEnable,
	input wire logic irq
);
	import iesr_pkg::*;
	logic take;
	logic ctlWr;
	logic wrPh_reg;
	logic [5:0] adr_reg;
	logic [31:0] dat_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// accepted address phase, and a write data phase to the control word
	assign take = hsel && htrans[1] && hready;
	assign ctlWr = wrPh_reg && adr_reg == OFS_CTRL_LO[7:2];
	// data kept a cycle so the landed value can be compared after the edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPh_reg <= 1'b0;
			adr_reg <= 6'h00;
			dat_reg <= 32'h0;
		end else begin
			wrPh_reg <= take && hwrite && hsize == HSIZE_WORD;
			dat_reg <= hwdata;
			if (take) begin
				adr_reg <= haddr[7:2];
			end
		end
	end
	chk_bus_okay: assert property (hresp == HRESP_OKAY)
		else $error("bad response");
	chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	chk_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_wait_cause: assert property ($fell(hreadyout) |-> $past(take) && !$past(hwrite))
		else $error("stray wait");
	chk_irq_sticky: assert property ($fell(irq) |-> $past(wrPh_reg))
		else $error("irq fell with no write");
	chk_ctrl_stable: assert property ($changed({portDisable, scanMasterEnable}) |-> $past(wrPh_reg))
		else $error("control changed with no write");
	chk_port_write: assert property (ctlWr |=> portDisable == dat_reg[3:0])
		else $error("port disable not written");
	chk_scan_write: assert property (ctlWr |=> scanMasterEnable == dat_reg[16])
		else $error("scan enable not written");
endmodule
bind iesr_error_status iesr_status_chk chk (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hreadyout, .hresp, .portDisable, .scanMasterEnable, .irq);

/* File: tb/iesr_error_status_test.sv */
// self-checking bench for the error status block
`timescale 1ns/1ns
module iesr_error_status_test;
	import iesr_pkg::*;
	localparam logic [6:0] REV = 7'h5a;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	// event inputs; ev is indexed by flag number
	logic [63:0] ev = 64'h0;
	logic [2:0] par = 3'h0;
	logic [1:0] rv = 2'h0, se = 2'h0, il = 2'h0, nk = 2'h0;
	logic hreadyout, hresp, irq, scanMasterEnable;
	logic [3:0] portDisable;
	logic [31:0] hrdata;
	int failures = 0;
	int checks_done = 0;
	int i, b;
	// retry limit of two keeps the nak runs short
	iesr_error_status #(.RETRY_LIMIT(4'h2)) dut (.clk(clk), .nrst(nrst), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.errLower(ev[46:0]), .inChanErr(ev[48:47]), .msgErr(ev[53:49]),
		.slaveDmaErr(ev[59:54]), .mdmaParityErr(par), .mdmaFormatErr(ev[63]),
		.mdmaRspValid(rv), .mdmaSendErrState(se), .mdmaIllegalFlags(il), .mdmaNak(nk),
		.boardRevisionPin(REV), .portDisable(portDisable),
		.scanMasterEnable(scanMasterEnable), .irq(irq));
	// 4 ns clock
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// one word transfer; requests held until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		cmp(hrdata, exp);
	endtask
	// one-cycle event pulse; k picks send error, illegal flags, nak
	task automatic fire(input logic [63:0] v, input logic [2:0] p, input logic [1:0] s,
		input logic [2:0] k);
		ev <= v;
		par <= p;
		rv <= s;
		se <= k[2] ? s : 2'h0;
		il <= k[1] ? s : 2'h0;
		nk <= k[0] ? s : 2'h0;
		@(posedge clk);
		{ev, par, rv, se, il, nk} <= '0;
		@(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#40000;
		failures++;
		$display("unexpected at %0t: watchdog", $time);
		report_and_stop();
	end
	// test sequence
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		for (i = 0; i < 13; i++) begin
			rd(8'(i * 4), i == 8 ? {17'h0, REV, 8'h00} : 32'h0);
		end
		for (i = 4; i < 13; i++) begin
			if (i != 8 && i != 11) begin
				wr(8'(i * 4), 32'hffffffff);
				rd(8'(i * 4), 32'h0);
			end
		end
		$display("registers done");
		// every flag source from 47 up except 60 and 61, with its interrupt disabled
		for (i = 0; i < 17; i++) begin
			b = i < 13 ? 47 + i : i < 16 ? 62 : 63;
			fire(64'h1 << b, i > 12 && i < 16 ? 3'h1 << (i - 13) : 3'h0, 2'h0, 3'h0);
			rd(OFS_FLAGS_HI, 32'h1 << (b - 32));
			cmp(irq, 32'h0);
			wr(OFS_FLAGS_HI, 32'h1 << (b - 32));
			rd(OFS_FLAGS_HI, 32'h0);
		end
		$display("flags done");
		wr(OFS_ENABLE_HI, 32'h0040_0000);
		rd(OFS_ENABLE_HI, 32'h0040_0000);
		fire(64'h1 << 54, 3'h0, 2'h0, 3'h0);
		cmp(irq, 32'h1);
		rd(OFS_ROUTER_HI, 32'h0000_0400);
		wr(OFS_FLAGS_HI, 32'h0040_0000);
		@(posedge clk);
		cmp(irq, 32'h0);
		rd(OFS_ROUTER_HI, 32'h0000_0400);
		wr(OFS_ROUTER_HI, 32'h0000_0400);
		rd(OFS_ROUTER_HI, 32'h0);
		fire(64'h1 << 55, 3'h0, 2'h0, 3'h0);
		cmp(irq, 32'h0);
		wr(OFS_ENABLE_HI, 32'h0080_0000);
		@(posedge clk);
		cmp(irq, 32'h1);
		rd(OFS_ROUTER_HI, 32'h0);
		wr(OFS_FLAGS_HI, 32'h0080_0000);
		wr(OFS_ENABLE_HI, 32'h0);
		$display("interrupt done");
		// per channel: illegal flags, send error, then nak runs broken by a clean reply
		for (i = 0; i < 2; i++) begin
			for (b = 1; b < 3; b++) begin
				fire(64'h0, 3'h0, 2'(1 << i), 3'(1 << b));
				rd(OFS_FLAGS_HI, 32'h1 << (28 + i));
				wr(OFS_FLAGS_HI, 32'h1 << (28 + i));
			end
			for (b = 0; b < 5; b++) begin
				fire(64'h0, 3'h0, 2'(1 << i), b == 2 ? 3'h0 : 3'h1);
			end
			rd(OFS_FLAGS_HI, 32'h0);
			fire(64'h0, 3'h0, 2'(1 << i), 3'h1);
			rd(OFS_FLAGS_HI, 32'h1 << (28 + i));
			wr(OFS_FLAGS_HI, 32'h1 << (28 + i));
		end
		$display("master dma done");
		for (i = 0; i < 4; i++) begin
			wr(OFS_CTRL_LO, 32'h0001_0000 | (32'h1 << i));
			@(posedge clk);
			cmp({27'h0, scanMasterEnable, portDisable}, {27'h0, 1'b1, 4'h1 << i});
			rd(OFS_CTRL_LO, {15'h0, 1'b1, 1'b0, REV, 4'h0, 4'h1 << i});
		end
		wr(OFS_CTRL_LO, 32'h0);
		@(posedge clk);
		cmp({27'h0, scanMasterEnable, portDisable}, 32'h0);
		$display("control done");
		report_and_stop();
	end
endmodule
